// File: rvd_line_model.sv
// Behavioural model of the line-side device that reports ring threshold crossings.
module rvd_line_model (
  input  wire logic       ref_clk_i, // Device clock.
  input  wire logic       ring_on_i, // Run a ring waveform.
  input  wire logic [1:0] level_i,   // Static level: 1 above, 2 below, else between.
  input  wire logic [7:0] phase_i,   // Cycles per quarter of a ring period.
  output logic            pos_o,     // High while above the positive threshold.
  output logic            neg_o      // High while below the negative threshold.
);
  logic [7:0] cnt_reg = 8'h00; // Cycles spent in the current quarter.
  logic [1:0] qtr_reg = 2'h0;  // Quarter: positive, gap, negative, gap.

  // Steps through the quarters of the ring; the gaps make the crossings alternate.
  always @(posedge ref_clk_i) begin
    if (!ring_on_i || cnt_reg >= phase_i - 8'h01) begin
      cnt_reg <= 8'h00;
      qtr_reg <= ring_on_i ? qtr_reg + 2'h1 : 2'h0;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // The line can never be above and below the thresholds at once.
  assign pos_o = ring_on_i ? (qtr_reg == 2'h0) : (level_i == 2'h1);
  assign neg_o = ring_on_i ? (qtr_reg == 2'h2) : (level_i == 2'h2);
endmodule

// File: rvd_pkg.sv
// Shared constants for the ring detection and validation block.
package rvd_pkg;

  // Clock rate of ref_clk_i.
  localparam int unsigned CLK_MHZ        = 40;
  localparam int unsigned CLK_HZ         = CLK_MHZ * 1000000;

  // Unqualified one-shot length, in seconds, and in clock cycles.
  localparam int unsigned ONESHOT_S      = 5;
  localparam int unsigned ONESHOT_CYCLES = ONESHOT_S * CLK_HZ;

  // Validation time base: one tick every VAL_TICK_US microseconds.
  localparam int unsigned VAL_TICK_US    = 2000;
  localparam int unsigned VAL_TICK_CYCLES = VAL_TICK_US * CLK_MHZ;

  // Ticks per unit of the duration, end timeout and delay fields.
  localparam logic [9:0]  VAL_DUR_TICKS  = 10'h032;
  localparam logic [9:0]  VAL_END_TICKS  = 10'h028;
  localparam logic [9:0]  VAL_DLY_TICKS  = 10'h080;

  // Ring sample codes placed on the transmit sample stream.
  localparam logic [15:0] SMP_POS        = 16'h7fff;
  localparam logic [15:0] SMP_NEG        = 16'h8000;
  localparam logic [15:0] SMP_REST_FW    = 16'h04cc;

  // Threshold codes sent to the line side: 15 V, 21 V and 45 V.
  localparam logic [1:0]  THR_15V        = 2'h0;
  localparam logic [1:0]  THR_21V        = 2'h1;
  localparam logic [1:0]  THR_45V        = 2'h2;

endpackage

// File: rvd_ring_detect.sv
// Ring detector top: pin, status flags, interrupt and ring samples.
module rvd_ring_detect #(
  parameter int unsigned ONESHOT_CYCLES = rvd_pkg::ONESHOT_CYCLES,
  parameter int unsigned TICK_CYCLES    = rvd_pkg::VAL_TICK_CYCLES
) (
  input  wire logic        ref_clk_i,                 // Device clock.
  input  wire logic        rst_i,                     // Async reset.
  input  wire logic        ring_sense_pos_input_i,    // Above positive threshold.
  input  wire logic        ring_sense_neg_input_i,    // Below negative threshold.
  input  wire logic        ring_threshold_sel_lo_i,   // Threshold select, low.
  input  wire logic        ring_threshold_sel_hi_i,   // Threshold select, high.
  input  wire logic        full_wave_ring_select_i,   // Full-wave detection.
  input  wire logic        ring_pin_polarity_i,       // Ring pin active high.
  input  wire logic        ring_irq_mask_i,           // Ring interrupt enable.
  input  wire logic        ring_irq_flag_clear_i,     // Host clear strobe.
  input  wire logic        ring_edge_both_irq_i,      // Interrupt on both edges.
  input  wire logic        ring_validation_enable_i,  // Validation on.
  input  wire logic [5:0]  ring_low_freq_limit_i,     // Longest interval.
  input  wire logic [5:0]  ring_high_freq_limit_i,    // Shortest interval.
  input  wire logic [2:0]  ring_valid_duration_i,     // Tolerance duration.
  input  wire logic [3:0]  ring_end_timeout_i,        // End timeout.
  input  wire logic [2:0]  ring_indicate_delay_i,     // Indication delay.
  input  wire logic        sleep_mode_i,              // Low-power sleep.
  input  wire logic        bit_clock_valid_i,         // External bit clock ok.
  input  wire logic        off_hook_i,                // Device off-hook.
  input  wire logic        onhook_monitor_i,          // On-hook line monitor.
  input  wire logic        isolation_link_powerdown_i,// Link powered down.
  input  wire logic        irq_pin_function_enable_i, // Pin is interrupt.
  input  wire logic        irq_active_high_select_i,  // Interrupt active high.
  input  wire logic        sample_strobe_i,           // One pulse per sample.
  input  wire logic [15:0] transmit_sample_in_i,      // Normal transmit sample.
  output logic [15:0]      transmit_sample_out_o,     // Transmit sample stream.
  output logic [1:0]       ring_threshold_code_o,     // Threshold to line side.
  output logic             ring_above_pos_flag_o,     // Positive level flag.
  output logic             ring_below_neg_flag_o,     // Negative level flag.
  output logic             ring_detect_status_o,      // Ring status.
  output logic             ring_irq_flag_o,           // Sticky ring interrupt.
  output logic             ring_detect_pin_o,         // Ring pin drive level.
  output logic             ring_detect_pin_oe_o,      // Ring pin driven.
  output logic             analog_out_or_irq_pin_o,   // Interrupt pin level.
  output logic             analog_out_or_irq_pin_oe_o // Interrupt pin driven.
);

  // Two-stage synchronisers for the line-side crossing levels.
  logic pos_meta_reg;  // First stage, read only by the second.
  logic neg_meta_reg;  // First stage, read only by the second.
  logic pos_reg;       // Synchronised positive level.
  logic neg_reg;       // Synchronised negative level.
  logic det_prev_reg;  // Previous detect level for edge finding.

  // One-shot, time base and output state.
  logic [31:0] shot_reg;   // One-shot countdown.
  logic [31:0] tick_reg;   // Time base divider.
  logic        stat_reg;   // Registered ring status.
  logic        flag_reg;   // Sticky interrupt flag.
  logic        pin_reg;    // Registered ring pin assertion.
  logic [15:0] smp_reg;    // Registered transmit sample.

  // Validation engine link.
  rvd_val_if vif ();

  // Synchronise the crossing indications before any use.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pos_meta_reg <= 1'b0;
      neg_meta_reg <= 1'b0;
      pos_reg      <= 1'b0;
      neg_reg      <= 1'b0;
    end else begin
      pos_meta_reg <= ring_sense_pos_input_i;
      neg_meta_reg <= ring_sense_neg_input_i;
      pos_reg      <= pos_meta_reg;
      neg_reg      <= neg_meta_reg;
    end
  end

  // Level flags follow the synchronised crossing levels directly.
  assign ring_above_pos_flag_o = pos_reg;
  assign ring_below_neg_flag_o = neg_reg;

  // Detect level: positive only, or either polarity in full-wave.
  wire det      = pos_reg | (full_wave_ring_select_i & neg_reg);
  wire det_rise = det & ~det_prev_reg;

  // Edge history of the detect level.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) det_prev_reg <= 1'b0;
    else det_prev_reg <= det;
  end

  // One-shot: each new detection reloads it; off-hook empties it.
  wire shot_act = shot_reg != 32'h0000_0000;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) shot_reg <= 32'h0000_0000;
    else if (off_hook_i) shot_reg <= 32'h0000_0000;
    else if (det_rise) shot_reg <= ONESHOT_CYCLES;
    else if (shot_act) shot_reg <= shot_reg - 32'h0000_0001;
  end

  // Validation time base, one tick per TICK_CYCLES clocks.
  wire tick = tick_reg == 32'h0000_0000;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) tick_reg <= 32'h0000_0000;
    else if (tick) tick_reg <= TICK_CYCLES - 1;
    else tick_reg <= tick_reg - 32'h0000_0001;
  end

  // Validation runs when enabled, and in sleep only with a bit clock.
  wire val_on = ring_validation_enable_i & (~sleep_mode_i | bit_clock_valid_i);

  // Validation selected: status, and the pin in half-wave only, show its result even while sleep stops the engine.
  wire val_sel = ring_validation_enable_i;

  // Drive the engine's inputs.
  assign vif.run      = val_on;
  assign vif.clear    = off_hook_i;
  assign vif.tick     = tick;
  assign vif.pos      = pos_reg;
  assign vif.neg      = neg_reg;
  assign vif.low_lim  = ring_low_freq_limit_i;
  assign vif.high_lim = ring_high_freq_limit_i;
  assign vif.dur      = ring_valid_duration_i;
  assign vif.ring_end_timeout      = ring_end_timeout_i;
  assign vif.dly      = ring_indicate_delay_i;

  // Validation engine.
  rvd_validator u_val (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .vif       (vif)
  );

  // Status source: envelope when validating, else the one-shot.
  wire stat_src  = (val_sel ? vif.env : shot_act) & ~off_hook_i;
  wire stat_rise = stat_src & ~stat_reg;
  wire stat_fall = ~stat_src & stat_reg;

  // Interrupt events: rising edge always, falling edge on request.
  wire irq_evt = stat_rise | (ring_edge_both_irq_i & stat_fall);

  // Registered status and sticky flag; a new event beats a clear.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_reg <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      stat_reg <= stat_src;
      if (irq_evt) flag_reg <= 1'b1;
      else if (ring_irq_flag_clear_i) flag_reg <= 1'b0;
    end
  end

  assign ring_detect_status_o = stat_reg;
  assign ring_irq_flag_o      = flag_reg;

  // Interrupt pin: open drain, only in interrupt mode.
  wire irq_act    = flag_reg & ring_irq_mask_i;
  wire irq_level  = irq_act ^ ~irq_active_high_select_i;
  assign analog_out_or_irq_pin_o    = 1'b0;
  assign analog_out_or_irq_pin_oe_o = irq_pin_function_enable_i & ~irq_level;

  // Ring pin source: raw detect, or envelope / one-shot when validating.
  wire pin_src = !val_sel ? det
               : (full_wave_ring_select_i ? shot_act : vif.env);

  // Registered ring pin assertion.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) pin_reg <= 1'b0;
    else pin_reg <= pin_src;
  end

  // Open drain: pull low when the pin's level must be low.
  wire pin_level = pin_reg ^ ~ring_pin_polarity_i;
  assign ring_detect_pin_o    = 1'b0;
  assign ring_detect_pin_oe_o = ~pin_level;

  // Ring data replaces samples only with link up, on-hook and the on-hook monitor off.
  wire ring_data_on = ~isolation_link_powerdown_i & ~off_hook_i
                    & ~onhook_monitor_i;

  // Ring sample code; its MSB follows the ring polarity.
  wire [15:0] hw_smp = pos_reg ? rvd_pkg::SMP_POS : rvd_pkg::SMP_NEG;
  wire [15:0] fw_smp = pos_reg ? rvd_pkg::SMP_POS
                     : (neg_reg ? rvd_pkg::SMP_NEG : rvd_pkg::SMP_REST_FW);
  wire [15:0] ring_smp = full_wave_ring_select_i ? fw_smp : hw_smp;
  wire [15:0] smp_sel  = ring_data_on ? ring_smp : transmit_sample_in_i;

  // Sample register loads once per sample strobe.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) smp_reg <= 16'h0000;
    else if (sample_strobe_i) smp_reg <= smp_sel;
  end

  assign transmit_sample_out_o = smp_reg;

  // Threshold select to the line side.
  assign ring_threshold_code_o = ring_threshold_sel_hi_i ? rvd_pkg::THR_45V
                               : (ring_threshold_sel_lo_i ? rvd_pkg::THR_21V
                                                          : rvd_pkg::THR_15V);

endmodule

// File: rvd_ring_detect_props.sv
// Port-level property checker for the ring detection block.
module rvd_ring_detect_props #(
  parameter int unsigned ONESHOT_CYCLES = 200,
  parameter int unsigned TICK_CYCLES    = 4
) (
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        ring_sense_pos_input_i,
  input wire logic        ring_sense_neg_input_i,
  input wire logic        full_wave_ring_select_i,
  input wire logic        ring_pin_polarity_i,
  input wire logic        ring_irq_mask_i,
  input wire logic        ring_edge_both_irq_i,
  input wire logic        ring_validation_enable_i,
  input wire logic        off_hook_i,
  input wire logic        onhook_monitor_i,
  input wire logic        isolation_link_powerdown_i,
  input wire logic        irq_pin_function_enable_i,
  input wire logic        irq_active_high_select_i,
  input wire logic        sample_strobe_i,
  input wire logic [15:0] transmit_sample_in_i,
  input wire logic [15:0] transmit_sample_out_o,
  input wire logic        ring_above_pos_flag_o,
  input wire logic        ring_below_neg_flag_o,
  input wire logic        ring_detect_status_o,
  input wire logic        ring_irq_flag_o,
  input wire logic        ring_detect_pin_oe_o,
  input wire logic        analog_out_or_irq_pin_o,
  input wire logic        analog_out_or_irq_pin_oe_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  wire logic        det_w;     // Detection as the selected mode sees it.
  wire logic        ring_on_w; // Ring data may replace the sample stream.
  wire logic [15:0] code_w;    // Ring code implied by the present flags.
  assign det_w     = ring_above_pos_flag_o | (full_wave_ring_select_i & ring_below_neg_flag_o);
  assign ring_on_w = !isolation_link_powerdown_i && !off_hook_i && !onhook_monitor_i;
  assign code_w    = ring_above_pos_flag_o ? rvd_pkg::SMP_POS :
                     (ring_below_neg_flag_o || !full_wave_ring_select_i) ? rvd_pkg::SMP_NEG :
                     rvd_pkg::SMP_REST_FW;

  chk_flag_sync: assert property (
    {ring_above_pos_flag_o, ring_below_neg_flag_o} ==
    $past({ring_sense_pos_input_i, ring_sense_neg_input_i}, 2))
    else $error("Level flags do not follow the crossing inputs.");
  chk_status_start: assert property (
    $rose(det_w) && !ring_validation_enable_i && !off_hook_i |-> ##[1:3]
    (ring_detect_status_o || off_hook_i)) else $error("Status missed a detection.");
  chk_offhook_clear: assert property (off_hook_i |=> !ring_detect_status_o)
    else $error("Status survived off-hook.");
  chk_irq_pin_level: assert property (!analog_out_or_irq_pin_o &&
    analog_out_or_irq_pin_oe_o == (irq_pin_function_enable_i &
    ((ring_irq_flag_o & ring_irq_mask_i) ^ irq_active_high_select_i)))
    else $error("Interrupt pin drive is wrong.");
  chk_irq_on_rise: assert property ($rose(ring_detect_status_o) |-> ##[0:2] ring_irq_flag_o)
    else $error("Flag not set on status rise.");
  chk_irq_no_fall: assert property (
    !ring_edge_both_irq_i && !ring_irq_flag_o && $fell(ring_detect_status_o) |->
    !ring_irq_flag_o [*3]) else $error("Flag set on status fall.");
  chk_ring_pin_raw: assert property (
    (!ring_validation_enable_i && $stable(det_w) && $stable(ring_pin_polarity_i)) [*3] |->
    ring_detect_pin_oe_o == (det_w ^ ring_pin_polarity_i)) else $error("Ring pin drive is wrong.");
  chk_ring_sample: assert property (
    sample_strobe_i && ring_on_w |=> transmit_sample_out_o == $past(code_w))
    else $error("Ring sample code is wrong.");
  chk_bypass_sample: assert property (
    sample_strobe_i && !ring_on_w |=> transmit_sample_out_o == $past(transmit_sample_in_i))
    else $error("Normal sample not passed through.");

  cov_status_rise: cover property ($rose(ring_detect_status_o));
  cov_valid_ring: cover property (ring_validation_enable_i && $rose(ring_detect_status_o));
  cov_full_neg: cover property (full_wave_ring_select_i && $rose(ring_below_neg_flag_o));
endmodule

bind rvd_ring_detect rvd_ring_detect_props #(
  .ONESHOT_CYCLES(ONESHOT_CYCLES),
  .TICK_CYCLES   (TICK_CYCLES)
) i_rvd_ring_detect_props (.*);

// File: rvd_val_if.sv
// Carrier between the ring block top and its validation engine.
interface rvd_val_if;
  logic       run;       // Validation may operate this cycle.
  logic       clear;     // Force the engine back to idle.
  logic       tick;      // One-cycle time base pulse.
  logic       pos;       // Synchronised positive crossing level.
  logic       neg;       // Synchronised negative crossing level.
  logic [5:0] low_lim;   // Longest legal crossing interval, ticks.
  logic [5:0] high_lim;  // Shortest legal crossing interval, ticks.
  logic [2:0] dur;       // In-tolerance duration, duration units.
  logic [3:0] ring_end_timeout;       // End timeout, end units.
  logic [2:0] dly;       // Indication delay, delay units.
  logic       env;       // Validated ring envelope.

  // The top drives configuration and reads the envelope.
  modport ctrl (output run, clear, tick, pos, neg, low_lim, high_lim,
                output dur, ring_end_timeout, dly, input env);
  // The engine reads configuration and drives the envelope.
  modport eng  (input run, clear, tick, pos, neg, low_lim, high_lim,
                input dur, ring_end_timeout, dly, output env);
endinterface

// File: rvd_validator.sv
// Ring validation engine: frequency check, end timeout and delay.
module rvd_validator (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  rvd_val_if.eng    vif
);

  // One-hot engine states.
  typedef enum logic [2:0] {
    V_IDLE = 3'b001,
    V_FREQ = 3'b010,
    V_ENDC = 3'b100
  } rvd_vstate_t;

  rvd_vstate_t st_reg;      // Current state.
  rvd_vstate_t st_next;     // Next state.
  logic        pos_reg;     // Previous positive level.
  logic        neg_reg;     // Previous negative level.
  logic        last_pos_reg; // Polarity of the last crossing.
  logic [6:0]  ivl_reg;     // Ticks since the last alternating crossing.
  logic [9:0]  dur_reg;     // Ticks spent in tolerance.
  logic [9:0]  end_reg;     // Ticks since the last crossing.
  logic [9:0]  dly_reg;     // Ticks since first validation.
  logic        env_reg;     // Envelope.

  // Crossing events and limit comparisons.
  wire       pos_rise = vif.pos & ~pos_reg;
  wire       neg_rise = vif.neg & ~neg_reg;
  wire       any_x    = pos_rise | neg_rise;
  wire       alt_x    = (pos_rise & ~last_pos_reg) | (neg_rise & last_pos_reg);
  wire       too_slow = ivl_reg > {1'b0, vif.low_lim};
  wire       too_fast = ivl_reg < {1'b0, vif.high_lim};
  wire [9:0] dur_lim  = 10'(vif.dur) * rvd_pkg::VAL_DUR_TICKS;
  wire [9:0] end_lim  = 10'(vif.ring_end_timeout) * rvd_pkg::VAL_END_TICKS;
  wire [9:0] dly_lim  = 10'(vif.dly) * rvd_pkg::VAL_DLY_TICKS;
  wire       dur_done = dur_reg >= dur_lim;
  wire       end_done = end_reg >= end_lim;
  wire       dly_done = dly_reg >= dly_lim;
  wire       oot      = alt_x & (too_slow | too_fast);

  // Next state: check frequency, then watch only for the ring end.
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      V_IDLE: if (any_x) st_next = V_FREQ;
      V_FREQ: begin
        if (too_slow) st_next = V_IDLE;
        else if (dur_done) st_next = V_ENDC;
      end
      V_ENDC: if (end_done) st_next = V_IDLE;
      default: st_next = V_IDLE;
    endcase
    if (!vif.run || vif.clear) st_next = V_IDLE;
  end

  // State and edge history.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg       <= V_IDLE;
      pos_reg      <= 1'b0;
      neg_reg      <= 1'b0;
      last_pos_reg <= 1'b0;
    end else begin
      st_reg  <= st_next;
      pos_reg <= vif.pos;
      neg_reg <= vif.neg;
      if (any_x) last_pos_reg <= pos_rise;
    end
  end

  // Interval timer between alternating crossings, saturating.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) ivl_reg <= 7'h00;
    else if (alt_x || st_reg == V_IDLE) ivl_reg <= 7'h00;
    else if (vif.tick && ivl_reg != 7'h7f) ivl_reg <= ivl_reg + 7'h01;
  end

  // Duration in tolerance; an out-of-tolerance interval restarts it.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) dur_reg <= 10'h000;
    else if (st_reg != V_FREQ || oot) dur_reg <= 10'h000;
    else if (vif.tick && !dur_done) dur_reg <= dur_reg + 10'h001;
  end

  // End timer and indication delay, both live after validation.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      end_reg <= 10'h000;
      dly_reg <= 10'h000;
    end else if (st_reg != V_ENDC) begin
      end_reg <= 10'h000;
      dly_reg <= 10'h000;
    end else begin
      if (any_x) end_reg <= 10'h000;
      else if (vif.tick && !end_done) end_reg <= end_reg + 10'h001;
      if (vif.tick && !dly_done) dly_reg <= dly_reg + 10'h001;
    end
  end

  // Envelope rises only if the delay beats the end timeout.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) env_reg <= 1'b0;
    else if (st_next == V_IDLE) env_reg <= 1'b0;
    else if (st_reg == V_ENDC && dly_done && !end_done) env_reg <= 1'b1;
  end

  assign vif.env = env_reg;

endmodule

// File: tb_rvd_ring_detect.sv
// Self-checking testbench for the ring detection and validation block.
module tb_rvd_ring_detect;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk_i = 1'b0, rst_i = 1'b1, ring_on = 1'b0;
  logic [1:0]  level = 2'h0;
  logic [7:0]  phase = 8'h08;
  logic        ring_threshold_sel_lo_i = 1'b0, ring_threshold_sel_hi_i = 1'b0;
  logic        full_wave_ring_select_i = 1'b0, ring_pin_polarity_i = 1'b0;
  logic        ring_irq_mask_i = 1'b0, ring_irq_flag_clear_i = 1'b0, ring_edge_both_irq_i = 1'b0;
  logic        ring_validation_enable_i = 1'b0, sleep_mode_i = 1'b0, bit_clock_valid_i = 1'b1;
  logic        off_hook_i = 1'b0, onhook_monitor_i = 1'b0, isolation_link_powerdown_i = 1'b0;
  logic        irq_pin_function_enable_i = 1'b0, irq_active_high_select_i = 1'b0;
  logic        sample_strobe_i = 1'b0;
  logic [15:0] transmit_sample_in_i = 16'h1234;
  logic [5:0]  ring_low_freq_limit_i = 6'h0a, ring_high_freq_limit_i = 6'h02;
  logic [2:0]  ring_valid_duration_i = 3'h1, ring_indicate_delay_i = 3'h1;
  logic [3:0]  ring_end_timeout_i = 4'h1;
  logic        ring_sense_pos_input_i, ring_sense_neg_input_i;
  logic [15:0] transmit_sample_out_o;
  logic [1:0]  ring_threshold_code_o;
  logic        ring_above_pos_flag_o, ring_below_neg_flag_o, ring_detect_status_o;
  logic        ring_irq_flag_o, ring_detect_pin_o, ring_detect_pin_oe_o;
  logic        analog_out_or_irq_pin_o, analog_out_or_irq_pin_oe_o;
  int          n_fail = 0, total_checks = 0, cycles = 0;

  always #12.5 ref_clk_i = ~ref_clk_i;

  rvd_line_model i_rvd_line_model (.ref_clk_i, .ring_on_i(ring_on), .level_i(level),
    .phase_i(phase), .pos_o(ring_sense_pos_input_i), .neg_o(ring_sense_neg_input_i));
  // Short one-shot and tick so that every count fits the run.
  rvd_ring_detect #(.ONESHOT_CYCLES(200), .TICK_CYCLES(4)) i_rvd_ring_detect (.*);

  // Waits n rising edges, then settles at the falling edge.
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Holds a static line level long enough for the synchronisers.
  task automatic lvl(input logic [1:0] v);
    @(posedge ref_clk_i);
    level <= v;
    wt(6);
  endtask
  // Pulses the sample strobe and compares the sample it loads.
  task automatic samp(input logic [15:0] exp);
    @(posedge ref_clk_i);
    sample_strobe_i <= 1'b1;
    @(posedge ref_clk_i);
    sample_strobe_i <= 1'b0;
    wt(0);
    chk_word("sample", exp, transmit_sample_out_o);
  endtask
  // Host clear pulse for the sticky flag.
  task automatic clr();
    @(posedge ref_clk_i);
    ring_irq_flag_clear_i <= 1'b1;
    @(posedge ref_clk_i);
    ring_irq_flag_clear_i <= 1'b0;
    wt(1);
  endtask
  // Runs one validated ring case and checks the indication and its end.
  task automatic vcase(input logic [7:0] ph, input int len, input logic slp, input logic bck,
                       input logic exp);
    @(posedge ref_clk_i);
    sleep_mode_i      <= slp;
    bit_clock_valid_i <= bck;
    phase             <= ph;
    ring_on           <= 1'b1;
    wt(len);
    chk_bit("status", exp, ring_detect_status_o);
    chk_bit("irq flag", exp, ring_irq_flag_o);
    chk_bit("ring pin drive", exp, ring_detect_pin_oe_o);
    clr();
    @(posedge ref_clk_i);
    ring_on <= 1'b0;
    wt(400);
    chk_bit("status", 1'b0, ring_detect_status_o);
    chk_bit("irq flag", 1'b0, ring_irq_flag_o);
    $display("Test validation case done");
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    logic [1:0] thr;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    wt(1);
    chk_bit("status", 1'b0, ring_detect_status_o);
    chk_bit("ring pin drive", 1'b0, ring_detect_pin_oe_o);
    chk_bit("ring pin level", 1'b0, ring_detect_pin_o);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk_i);
      {ring_threshold_sel_hi_i, ring_threshold_sel_lo_i} <= 2'(i);
      wt(0);
      thr = i[1] ? rvd_pkg::THR_45V : (i[0] ? rvd_pkg::THR_21V : rvd_pkg::THR_15V);
      chk_word("threshold", {14'h0, thr}, {14'h0, ring_threshold_code_o});
    end
    lvl(2'h1);
    chk_bit("pos flag", 1'b1, ring_above_pos_flag_o);
    chk_bit("ring pin drive", 1'b1, ring_detect_pin_oe_o);
    chk_bit("status", 1'b1, ring_detect_status_o);
    chk_bit("irq pin drive", 1'b0, analog_out_or_irq_pin_oe_o);
    samp(rvd_pkg::SMP_POS);
    lvl(2'h2);
    chk_bit("neg flag", 1'b1, ring_below_neg_flag_o);
    chk_bit("ring pin drive", 1'b0, ring_detect_pin_oe_o);
    samp(rvd_pkg::SMP_NEG);
    lvl(2'h0);
    samp(rvd_pkg::SMP_NEG);
    @(posedge ref_clk_i);
    irq_pin_function_enable_i <= 1'b1;
    ring_irq_mask_i           <= 1'b1;
    wt(0);
    chk_bit("irq pin drive", 1'b1, analog_out_or_irq_pin_oe_o);
    @(posedge ref_clk_i);
    irq_active_high_select_i <= 1'b1;
    wt(0);
    chk_bit("irq pin drive", 1'b0, analog_out_or_irq_pin_oe_o);
    clr();
    chk_bit("irq flag", 1'b0, ring_irq_flag_o);
    chk_bit("irq pin drive", 1'b1, analog_out_or_irq_pin_oe_o);
    @(posedge ref_clk_i);
    ring_pin_polarity_i      <= 1'b1;
    irq_active_high_select_i <= 1'b0;
    wt(4);
    chk_bit("ring pin drive", 1'b1, ring_detect_pin_oe_o);
    $display("Test half-wave done");
    @(posedge ref_clk_i);
    full_wave_ring_select_i <= 1'b1;
    ring_edge_both_irq_i    <= 1'b1;
    wt(3);
    samp(rvd_pkg::SMP_REST_FW);
    lvl(2'h2);
    chk_bit("ring pin drive", 1'b0, ring_detect_pin_oe_o);
    samp(rvd_pkg::SMP_NEG);
    lvl(2'h1);
    samp(rvd_pkg::SMP_POS);
    lvl(2'h0);
    clr();
    wt(150);
    chk_bit("status", 1'b1, ring_detect_status_o);
    wt(80);
    chk_bit("status", 1'b0, ring_detect_status_o);
    chk_bit("irq flag", 1'b1, ring_irq_flag_o);
    $display("Test full-wave done");
    lvl(2'h1);
    @(posedge ref_clk_i);
    off_hook_i           <= 1'b1;
    transmit_sample_in_i <= 16'h5a5a;
    wt(2);
    chk_bit("status", 1'b0, ring_detect_status_o);
    samp(16'h5a5a);
    @(posedge ref_clk_i);
    off_hook_i                 <= 1'b0;
    isolation_link_powerdown_i <= 1'b1;
    samp(16'h5a5a);
    @(posedge ref_clk_i);
    isolation_link_powerdown_i <= 1'b0;
    onhook_monitor_i           <= 1'b1;
    samp(16'h5a5a);
    @(posedge ref_clk_i);
    onhook_monitor_i <= 1'b0;
    samp(rvd_pkg::SMP_POS);
    lvl(2'h0);
    $display("Test sample path done");
    @(posedge ref_clk_i);
    full_wave_ring_select_i  <= 1'b0;
    ring_edge_both_irq_i     <= 1'b0;
    ring_pin_polarity_i      <= 1'b0;
    ring_validation_enable_i <= 1'b1;
    wt(300);
    clr();
    vcase(8'h08, 1200, 1'b0, 1'b1, 1'b1);
    vcase(8'h01, 1200, 1'b0, 1'b1, 1'b0);
    vcase(8'h08, 300, 1'b0, 1'b1, 1'b0);
    vcase(8'h08, 1200, 1'b1, 1'b0, 1'b0);
    vcase(8'h08, 1200, 1'b1, 1'b1, 1'b1);
    summarize();
  end
endmodule
